// >>> src/sdc_device.sv
// Command, data and mask timing core of a four-bank synchronous DRAM
// Assumes pins arrive unsynchronised; bus wire resolution is outside
`include "sdc_map.svh"
`timescale 1ns/10ps
`default_nettype none

// Contract
// - read or write commands may follow each other every cycle.
// - clock enable sampled low suspends the device one cycle later.
// - clock enable sampled high resumes the device one cycle later.
// - write mask blocks the data sampled on the same edge.
// - read mask puts outputs in high impedance two cycles later.
// - first write word arrives on the same edge as the write command.
// - precharge cuts a read; outputs float after read-latency cycles.
// - auto precharge starts one clock after the last write beat.
module sdc_device (
    input wire logic clock,
    input wire logic srst,
    input wire logic pin_cke,
    input wire sdc_pkg::sdc_pins_t pin_bus,
    output logic [`SDC_DW-1:0] dq_out_r,
    output logic dq_oe_r,
    output logic suspended_r,
    output logic wr_ready_r,
    output logic [`SDC_NBANK-1:0] bank_open_r,
    output logic [`SDC_REFW-1:0] refresh_cnt_r
);
    import sdc_pkg::*;

    function automatic logic [`SDC_MAW-1:0] cell_addr(
        input logic [`SDC_BW-1:0] bank,
        input logic [`SDC_CBITS-1:0] col
    );
        cell_addr = {bank, col};
    endfunction : cell_addr

    // Pin synchronisers
    logic cke_m_r;
    logic cke_s_r;
    sdc_pins_t pins_m_r;
    sdc_pins_t pins_s_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            cke_m_r <= 1'b1;
            cke_s_r <= 1'b1;
        end else begin
            cke_m_r <= pin_cke;
            cke_s_r <= cke_m_r;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pins_m_r <= '0;
            pins_s_r <= '0;
        end else begin
            pins_m_r <= pin_bus;
            pins_s_r <= pins_m_r;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            suspended_r <= 1'b0;
        end else begin
            suspended_r <= !cke_s_r;
        end
    end

    // Command decode
    logic live;
    logic is_act;
    logic is_rd;
    logic is_wr;
    logic is_pre;
    logic is_stop;
    logic is_ref;
    logic is_mode;
    logic col_cmd;
    logic [`SDC_NBANK-1:0] busy;
    logic all_idle;

    assign live = !suspended_r;
    assign is_act = live && (pins_s_r.cmd == SDC_ACT);
    assign is_rd = live && (pins_s_r.cmd == SDC_RD);
    assign is_wr = live && (pins_s_r.cmd == SDC_WR);
    assign is_pre = live && (pins_s_r.cmd == SDC_PRE);
    assign is_stop = live && (pins_s_r.cmd == SDC_STOP);
    assign is_ref = live && (pins_s_r.cmd == SDC_REF);
    assign is_mode = live && (pins_s_r.cmd == SDC_MODE);
    assign col_cmd = (is_rd || is_wr) && bank_open_r[pins_s_r.bank];
    assign all_idle = (bank_open_r == '0) && (busy == '0);

    // Burst state
    logic [`SDC_BLW-1:0] left_r;
    logic [`SDC_BW-1:0] bbank_r;
    logic [`SDC_CBITS-1:0] bcol_r;
    logic bwr_r;
    logic bap_r;
    logic pre_hit;
    logic stop_hit;

    assign pre_hit = is_pre
        && (pins_s_r.addr[`SDC_AP_BIT] || (pins_s_r.bank == bbank_r));
    assign stop_hit = (left_r != '0) && (is_stop || pre_hit);

    always_ff @(posedge clock) begin
        if (srst) begin
            left_r <= '0;
            bbank_r <= '0;
            bcol_r <= '0;
            bwr_r <= 1'b0;
            bap_r <= 1'b0;
        end else if (col_cmd) begin
            left_r <= `SDC_BLW'(`SDC_BL - 1);
            bbank_r <= pins_s_r.bank;
            bcol_r <= pins_s_r.addr[`SDC_CBITS-1:0] + 1'b1;
            bwr_r <= is_wr;
            bap_r <= pins_s_r.addr[`SDC_AP_BIT];
        end else if (stop_hit) begin
            left_r <= '0;
        end else if (live && (left_r != '0)) begin
            left_r <= left_r - 1'b1;
            bcol_r <= bcol_r + 1'b1;
        end
    end

    // Beat served in this cycle
    logic beat_v;
    logic beat_wr;
    logic beat_last;
    logic beat_ap;
    logic [`SDC_BW-1:0] beat_bank;
    logic [`SDC_MAW-1:0] beat_addr;
    logic rd_issue;
    logic push;
    logic ap_wr_last;

    assign beat_v = col_cmd || (live && (left_r != '0) && !stop_hit);
    assign beat_wr = col_cmd ? is_wr : bwr_r;
    assign beat_bank = col_cmd ? pins_s_r.bank : bbank_r;
    assign beat_addr = col_cmd
        ? cell_addr(pins_s_r.bank, pins_s_r.addr[`SDC_CBITS-1:0])
        : cell_addr(bbank_r, bcol_r);
    assign beat_last = beat_v
        && (col_cmd ? (`SDC_BL == 1) : (left_r == `SDC_BLW'(1)));
    assign beat_ap = col_cmd ? pins_s_r.addr[`SDC_AP_BIT] : bap_r;
    assign rd_issue = beat_v && !beat_wr;
    // Masked beats never reach the array
    assign push = beat_v && beat_wr && !pins_s_r.dqm;
    assign ap_wr_last = beat_last && beat_wr && beat_ap;

    // Auto precharge waits one clock after the last beat
    logic ap_pend_r;
    logic [`SDC_BW-1:0] ap_bank_r;
    logic [`SDC_NBANK-1:0] tmr_start;

    always_ff @(posedge clock) begin
        if (srst) begin
            ap_pend_r <= 1'b0;
            ap_bank_r <= '0;
        end else if (live) begin
            ap_pend_r <= beat_last && beat_ap;
            ap_bank_r <= beat_bank;
        end
    end

    genvar gb;
    generate
        for (gb = 0; gb < `SDC_NBANK; gb++) begin : g_bank
            assign tmr_start[gb] = (live && ap_pend_r
                && (ap_bank_r == `SDC_BW'(gb)))
                || (is_pre && bank_open_r[gb]
                && (pins_s_r.addr[`SDC_AP_BIT]
                || (pins_s_r.bank == `SDC_BW'(gb))));
            sdc_bank_timer u_tmr (
                .clock(clock),
                .srst(srst),
                .start(tmr_start[gb]),
                .busy(busy[gb])
            );
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (srst) begin
            bank_open_r <= '0;
        end else begin
            for (int b = 0; b < `SDC_NBANK; b++) begin
                if (tmr_start[b]) begin
                    bank_open_r[b] <= 1'b0;
                end else if (is_act && !busy[b]
                        && (pins_s_r.bank == `SDC_BW'(b))) begin
                    bank_open_r[b] <= 1'b1;
                end
            end
        end
    end

    // Mode load and refresh bookkeeping
    logic [`SDC_LAT_W-1:0] lat_r;
    logic [`SDC_LAT_W-1:0] lat_field;

    assign lat_field = pins_s_r.addr[`SDC_LAT_LSB +: `SDC_LAT_W];

    always_ff @(posedge clock) begin
        if (srst) begin
            lat_r <= `SDC_LAT_RST;
        end else if (is_mode && all_idle
                && (lat_field == `SDC_LAT2 || lat_field == `SDC_LAT3)) begin
            lat_r <= lat_field;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            refresh_cnt_r <= '0;
        end else if (is_ref && all_idle) begin
            refresh_cnt_r <= refresh_cnt_r + 1'b1;
        end
    end

    // Write buffer and storage array
    sdc_wbeat_t wb_in;
    sdc_wbeat_t wb_out;
    logic wb_in_ready;
    logic wb_out_valid;
    logic drain_ok;
    logic [`SDC_DW-1:0] cell_r [0:`SDC_MDEPTH-1];

    assign wb_in.addr = beat_addr;
    assign wb_in.data = pins_s_r.dq;
    // The array has one port; a read beat takes it first
    assign drain_ok = !rd_issue;

    sdc_fifo #(
        .W($bits(sdc_wbeat_t)),
        .D(`SDC_FIFO_DEPTH)
    ) u_wbuf (
        .clock(clock),
        .srst(srst),
        .in_valid(push),
        .in_ready(wb_in_ready),
        .in_data(wb_in),
        .out_valid(wb_out_valid),
        .out_ready(drain_ok),
        .out_data(wb_out)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_ready_r <= 1'b0;
        end else begin
            wr_ready_r <= wb_in_ready;
        end
    end

    always_ff @(posedge clock) begin
        if (wb_out_valid && drain_ok) begin
            cell_r[wb_out.addr] <= wb_out.data;
        end
    end

    // Read pipeline, frozen while suspended
    logic sh1_v_r;
    logic sh2_v_r;
    logic [`SDC_DW-1:0] sh1_d_r;
    logic [`SDC_DW-1:0] sh2_d_r;
    logic mask_r;
    logic sel_v;
    logic [`SDC_DW-1:0] sel_d;

    always_ff @(posedge clock) begin
        if (srst) begin
            sh1_v_r <= 1'b0;
            sh2_v_r <= 1'b0;
            sh1_d_r <= '0;
            sh2_d_r <= '0;
        end else if (live) begin
            sh1_v_r <= rd_issue;
            sh1_d_r <= cell_r[beat_addr];
            sh2_v_r <= sh1_v_r;
            sh2_d_r <= sh1_d_r;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mask_r <= 1'b0;
        end else if (live) begin
            mask_r <= pins_s_r.dqm;
        end
    end

    assign sel_v = (lat_r == `SDC_LAT2) ? sh1_v_r : sh2_v_r;
    assign sel_d = (lat_r == `SDC_LAT2) ? sh1_d_r : sh2_d_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            dq_oe_r <= 1'b0;
            dq_out_r <= '0;
        end else if (live) begin
            dq_oe_r <= sel_v && !mask_r;
            dq_out_r <= sel_d;
        end
    end

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    property p_susp_entry;
        !cke_s_r |=> suspended_r && !is_rd && !is_wr;
    endproperty
    a_susp_entry: assert property (p_susp_entry)
        else $error("suspend not entered one cycle after low enable");

    property p_susp_exit;
        $rose(cke_s_r) |=> !suspended_r;
    endproperty
    a_susp_exit: assert property (p_susp_exit)
        else $error("suspend not left one cycle after high enable");

    property p_col_spacing;
        col_cmd |-> beat_v ##1 (left_r == `SDC_BLW'(`SDC_BL - 1));
    endproperty
    a_col_spacing: assert property (p_col_spacing)
        else $error("column command not accepted in its own cycle");

    property p_wr_mask;
        (beat_v && beat_wr && pins_s_r.dqm) |-> !push;
    endproperty
    a_wr_mask: assert property (p_wr_mask)
        else $error("masked write beat reached the buffer");

    property p_wr_first;
        (col_cmd && is_wr && !pins_s_r.dqm && wb_in_ready)
            |-> push && (wb_in.data == pins_s_r.dq);
    endproperty
    a_wr_first: assert property (p_wr_first)
        else $error("first write word not taken with the command");

    property p_rd_mask;
        (pins_s_r.dqm && live) ##1 live |=> !dq_oe_r;
    endproperty
    a_rd_mask: assert property (p_rd_mask)
        else $error("read mask did not float outputs after two cycles");

    property p_trunc_l3;
        (stop_hit && !bwr_r && lat_r == `SDC_LAT3) ##1 live [*2]
            |=> !dq_oe_r;
    endproperty
    a_trunc_l3: assert property (p_trunc_l3)
        else $error("cut read still drove outputs at latency three");

    property p_trunc_l2;
        (stop_hit && !bwr_r && lat_r == `SDC_LAT2) ##1 live |=> !dq_oe_r;
    endproperty
    a_trunc_l2: assert property (p_trunc_l2)
        else $error("cut read still drove outputs at latency two");

    property p_ap_start;
        (ap_wr_last && live) |-> (tmr_start[beat_bank] == 1'b0
            || is_pre) ##1 (tmr_start[ap_bank_r] || suspended_r);
    endproperty
    a_ap_start: assert property (p_ap_start)
        else $error("auto precharge did not start one clock after data");

endmodule : sdc_device

`default_nettype wire

// >>> pkg/sdc_map.svh
// Named offsets, field positions, reset values and timing counts
// Assumes a single 40 MHz clock; included by the package and the design
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

`define SDC_DW 16
`define SDC_AW 12
`define SDC_NBANK 4
`define SDC_BW 2
`define SDC_CBITS 4
`define SDC_MAW 6
`define SDC_MDEPTH 64
`define SDC_BL 4
`define SDC_BLW 3
`define SDC_AP_BIT 10
`define SDC_LAT_LSB 4
`define SDC_LAT_W 2
`define SDC_LAT_RST 2'h3
`define SDC_LAT2 2'h2
`define SDC_LAT3 2'h3
`define SDC_REFW 13
`define SDC_FIFO_DEPTH 4
`define SDC_CLK_MHZ 40
`define SDC_RP_NS 18
`define SDC_RP_CYC ((`SDC_RP_NS * `SDC_CLK_MHZ + 999) / 1000)
`define SDC_TMRW 3

`endif

// >>> pkg/sdc_pkg.sv
// Types shared by the device core, its write buffer and the bench controller model
// Assumes the constants header is on the include path
`include "sdc_map.svh"

package sdc_pkg;

    typedef enum logic [2:0] {
        SDC_NOP,
        SDC_ACT,
        SDC_RD,
        SDC_WR,
        SDC_PRE,
        SDC_STOP,
        SDC_REF,
        SDC_MODE
    } sdc_cmd_t;

    typedef struct packed {
        sdc_cmd_t cmd;
        logic [`SDC_BW-1:0] bank;
        logic [`SDC_AW-1:0] addr;
        logic dqm;
        logic [`SDC_DW-1:0] dq;
    } sdc_pins_t;

    typedef struct packed {
        logic [`SDC_MAW-1:0] addr;
        logic [`SDC_DW-1:0] data;
    } sdc_wbeat_t;

endpackage : sdc_pkg

// >>> src/sdc_fifo.sv
// Write-beat buffer between the pin side and the storage array
// Assumes one clock; the drain side may stall at any time
`include "sdc_map.svh"
`timescale 1ns/10ps
`default_nettype none

module sdc_fifo #(
    parameter int W = 22,
    parameter int D = `SDC_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(D);

    logic [W-1:0] mem_r [0:D-1];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (PW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_r <= '0;
        end else if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

endmodule : sdc_fifo

`default_nettype wire

// >>> src/sdc_bank_timer.sv
// Precharge period timer for one bank
// Assumes start is a one-cycle pulse from the device core
`include "sdc_map.svh"
`timescale 1ns/10ps
`default_nettype none

module sdc_bank_timer (
    input wire logic clock,
    input wire logic srst,
    input wire logic start,
    output logic busy
);
    logic [`SDC_TMRW-1:0] cnt_r;

    assign busy = (cnt_r != '0);

    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= `SDC_TMRW'(`SDC_RP_CYC);
        end else if (busy) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

endmodule : sdc_bank_timer

`default_nettype wire

// >>> bench/sdc_ctrl_model.sv
// Command-side model of the memory controller driving the device pins
// Assumes the bench calls its tasks; pins change on falling edges only
`timescale 1ns/10ps
`default_nettype none

module sdc_ctrl_model (
    input wire logic clock,
    output logic pin_cke,
    output var sdc_pkg::sdc_pins_t pin_bus
);
    import sdc_pkg::*;

    initial begin
        pin_cke = 1'b1;
        pin_bus = '0;
    end

    // One command cycle on the pins
    task put(input sdc_cmd_t c, input logic [1:0] b, input logic [11:0] a,
            input logic m, input logic [15:0] d);
        @(negedge clock);
        pin_bus <= '{cmd: c, bank: b, addr: a, dqm: m, dq: d};
    endtask : put

    // Idle data lines flip every cycle so no stale word lingers
    task idle(input int n);
        repeat (n) begin
            put(SDC_NOP, 2'($urandom), 12'($urandom), 1'b0, ~pin_bus.dq);
        end
    endtask : idle

    task set_cke(input logic v);
        @(negedge clock);
        pin_cke <= v;
    endtask : set_cke

    // Four-beat write; first word rides with the command
    task wr(input logic [1:0] b, input logic [3:0] c, input logic [63:0] d,
            input logic [3:0] m, input logic ap);
        put(SDC_WR, b, {1'b0, ap, 6'h0, c}, m[0], d[15:0]);
        for (int i = 1; i < 4; i++) begin
            put(SDC_NOP, b, 12'h0, m[i], d[16*i+:16]);
        end
        idle(ap ? 5 : 2);
    endtask : wr
endmodule : sdc_ctrl_model

`default_nettype wire

// >>> bench/test_sdram_command_cycle_timing.sv
// Self-checking bench for the device timing core
// Assumes the controller model drives all pins; one 40 MHz clock
`timescale 1ns/10ps
`default_nettype none

module test_sdram_command_cycle_timing;
    import sdc_pkg::*;

    logic clock;
    logic srst;
    logic pin_cke;
    sdc_pins_t pin_bus;
    logic [15:0] dq_out_r;
    logic dq_oe_r;
    logic suspended_r;
    logic wr_ready_r;
    logic [3:0] bank_open_r;
    logic [12:0] refresh_cnt_r;
    int num_errors = 0;
    int n_compared = 0;
    int lat;
    logic [15:0] em [4][16];

    sdc_device sdc_device_i (.clock(clock), .srst(srst), .pin_cke(pin_cke),
        .pin_bus(pin_bus), .dq_out_r(dq_out_r), .dq_oe_r(dq_oe_r),
        .suspended_r(suspended_r), .wr_ready_r(wr_ready_r),
        .bank_open_r(bank_open_r), .refresh_cnt_r(refresh_cnt_r));
    sdc_ctrl_model sdc_ctrl_model_i (.clock(clock), .pin_cke(pin_cke),
        .pin_bus(pin_bus));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task check(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    function automatic logic [15:0] watch(input int sel);
        case (sel)
            0: return {12'h0, bank_open_r};
            1: return {15'h0, suspended_r};
            default: return {3'h0, refresh_cnt_r};
        endcase
    endfunction : watch

    // Rising edges from the next falling edge until an output reaches v
    task edges_to(input int sel, input logic [15:0] v, output int n);
        n = 0;
        @(negedge clock);
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (watch(sel) !== v && n < 30);
    endtask : edges_to

    // Read burst with optional mask beat, cutting precharge (burst stop at latency two), or a
    // second read one cycle later; 9 means none
    task rd(input logic [1:0] b, input logic [3:0] c, input int mb,
            input int cut, input bit nxt);
        int k;
        logic [3:0] a;
        logic eo;
        fork
            for (int j = 0; j < 8; j++) begin
                sdc_ctrl_model_i.put(sdc_cmd_t'(j == 0 || (nxt && j == 1)
                    ? SDC_RD : (j != cut ? SDC_NOP
                    : (lat == 2 ? SDC_STOP : SDC_PRE))), b,
                    {8'h0, j == 1 ? c + 4'h8 : c}, j == lat - 2 + mb,
                    16'($urandom));
            end
            begin
                @(negedge clock);
                for (int e = 1; e < lat + 9; e++) begin
                    @(posedge clock);
                    #1;
                    k = e - 2 - lat;
                    a = (nxt && k > 0) ? c + 4'h7 + k[3:0] : c + k[3:0];
                    eo = k >= 0 && k < (nxt ? 5 : 4) && k < cut && k != mb;
                    check("read enable", {15'h0, dq_oe_r}, {15'h0, eo});
                    if (eo) begin
                        check("read data", dq_out_r, em[b][a]);
                    end
                end
            end
        join
    endtask : rd

    initial begin
        #(25 * 5000);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        logic [63:0] d;
        logic [3:0] m;
        int n;
        int b;
        void'($urandom(81));
        srst = 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        srst = 1'b0;
        check("ready in reset", {15'h0, wr_ready_r}, 16'h0);
        for (int l = 2; l < 4; l++) begin
            lat = l;
            b = $urandom_range(3);
            sdc_ctrl_model_i.put(SDC_MODE, b[1:0],
                {6'($urandom), 2'(l), 4'($urandom)}, 1'b0, 16'($urandom));
            sdc_ctrl_model_i.idle(2);
            fork
                sdc_ctrl_model_i.put(SDC_ACT, b[1:0], 12'($urandom), 1'b0,
                    16'($urandom));
                edges_to(0, 16'h1 << b, n);
            join
            check("activate delay", n[15:0], 16'h3);
            sdc_ctrl_model_i.idle(2);
            for (int c = 0; c < 20; c += 4) begin
                d = {$urandom, $urandom};
                m = (c == 16) ? 4'h1 << $urandom_range(3) : 4'h0;
                for (int i = 0; i < 4; i++) begin
                    if (!m[i]) em[b][(c + i) % 16] = d[16*i+:16];
                end
                sdc_ctrl_model_i.wr(b[1:0], c[3:0], d, m, 1'b0);
            end
            check("write ready", {15'h0, wr_ready_r}, 16'h1);
            sdc_ctrl_model_i.idle(4);
            rd(b[1:0], 4'($urandom), 9, 9, 1'b0);
            rd(b[1:0], 4'h2, $urandom_range(3), 9, 1'b0);
            rd(b[1:0], 4'hc, 9, 9, 1'b1);
            rd(b[1:0], 4'h0, 9, 1 + $urandom_range(2), 1'b0);
            sdc_ctrl_model_i.put(SDC_ACT, b[1:0], 12'($urandom), 1'b0,
                16'($urandom));
            sdc_ctrl_model_i.idle(2);
            fork
                sdc_ctrl_model_i.wr(b[1:0], 4'h8, {$urandom, $urandom},
                    4'($urandom), 1'b1);
                edges_to(0, 16'h0, n);
            join
            check("auto precharge close", n[15:0], 16'h7);
            fork
                begin
                    // Refresh stands on the pins for exactly one cycle
                    sdc_ctrl_model_i.put(SDC_REF, b[1:0], 12'($urandom),
                        1'b0, 16'($urandom));
                    sdc_ctrl_model_i.idle(1);
                end
                edges_to(2, 16'(l - 1), n);
            join
            check("refresh count", n[15:0], 16'h3);
            fork
                sdc_ctrl_model_i.set_cke(1'b0);
                edges_to(1, 16'h1, n);
            join
            check("suspend entry", n[15:0], 16'h3);
            sdc_ctrl_model_i.put(SDC_ACT, b[1:0], 12'($urandom), 1'b0,
                16'($urandom));
            sdc_ctrl_model_i.idle(3);
            check("ignored while suspended", {12'h0, bank_open_r}, 16'h0);
            fork
                sdc_ctrl_model_i.set_cke(1'b1);
                edges_to(1, 16'h0, n);
            join
            check("suspend exit", n[15:0], 16'h3);
            sdc_ctrl_model_i.idle(2);
        end
        tally_and_finish();
    end
endmodule : test_sdram_command_cycle_timing

`default_nettype wire
